// >>> logic/asswc_ctrl.sv
// area-4 sram controller: wait control register on classic wishbone, strobe sequencer
// assumes one access requester holding accReq until accDone, pins registered on clk_sys
//
// Summary of operation
// - reads of bits 31..21, 19 and 15..13 of the wait register return zero
// - byte strobe style only changes timing in byte-selection sram mode
// - style 0: byte enables pulse as strobe, direction held low through writes
// - style 1: byte enables held through the access, direction pulses at write timing
// - write wait code 000 reuses the read wait count for writes
// - write wait codes 001 to 111 give code minus one wait cycles, 0 to 6
// - strobe follows address and chip select by 0.5, 1.5, 2.5 or 3.5 cycles
// - read wait codes give 0..6, 8, 10, 12, 14, 18, 24 cycles; 1101..1111 prohibited
// - ext_wait_ignore 0 honours the external wait input, 1 ignores it, even at zero waits
`timescale 1ns/1ps
`default_nettype none
module asswc_ctrl
    import asswc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        accReq,
    input  wire logic        accWrite,
    input  wire logic [25:0] accAddr,
    input  wire logic [31:0] accWdata,
    input  wire logic [3:0]  accByteEn,
    output logic             accDone,
    output logic      [31:0] accRdata,
    input  wire logic        byteSelMode,
    input  wire logic        extWaitN,
    input  wire logic [31:0] memRdata,
    output logic             memBusClk,
    output logic             chipSelectN,
    output logic             readStrobeN,
    output logic      [3:0]  byteLaneEnableN,
    output logic             rdWrN,
    output logic      [25:0] memAddr,
    output logic      [31:0] memWdata,
    output logic             memDataOeN
);
    logic [31:0]      wcr_ff;
    logic [31:0]      wbDat_ff;
    logic             wbAck_ff;
    asswc_state_e     state_ff;
    asswc_state_e     nxt_state;
    logic             busClk_ff;
    logic             curWrite_ff;
    logic [3:0]       curBe_ff;
    logic             curBs_ff;
    logic             accDone_ff;
    logic [31:0]      accRdata_ff;
    logic             csN_ff;
    logic             rdN_ff;
    logic [3:0]       beN_ff;
    logic             rdWrN_ff;
    logic [25:0]      memAddr_ff;
    logic [31:0]      memWdata_ff;
    logic             oeN_ff;
    logic             timerLoad;
    logic [CNT_W-1:0] timerVal;
    logic             expired;
    logic             wbReq;
    logic             accept;
    logic             waitHeld;
    logic [4:0]       waitCycles;
    logic [CNT_W-1:0] phaseCnt_ff;
    logic             pinWrite;
    logic [3:0]       pinBe;
    logic             pinBs;

    function automatic logic [4:0] readWaits(input logic [3:0] code);
        logic [4:0] w;
        w = RDWAIT_BAD_WAIT;
        if (code <= 4'h6) begin
            w = {1'b0, code};
        end else if (code <= 4'ha) begin
            w = 5'(({1'b0, code} - 5'h3) << 1);
        end else if (code == 4'hb) begin
            w = 5'h12;
        end else if (code < RDWAIT_BAD_CODE) begin
            w = 5'h18;
        end
        return w;
    endfunction

    function automatic logic [4:0] writeWaits(input logic [2:0] wtCode, input logic [3:0] rdCode);
        logic [4:0] w;
        w = readWaits(rdCode);
        if (wtCode != 3'h0) begin
            w = 5'({2'b00, wtCode} - 5'h1);
        end
        return w;
    endfunction

    function automatic logic [CNT_W-1:0] oddHalves(input logic [4:0] n);
        return CNT_W'({n, 1'b1}); // 2n+1 half cycles
    endfunction

    // register file: wishbone classic, one wait state, ack for one cycle
    assign wbReq = wb_cyc_i && wb_stb_i && !wbAck_ff;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wbAck_ff <= 1'b0;
        end else begin
            wbAck_ff <= wbReq;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wcr_ff <= WCR_RESET;
        end else if (wbReq && wb_we_i && wb_adr_i == WCR_OFFSET) begin
            for (int i = 0; i < 4; i++) begin
                if (wb_sel_i[i]) begin
                    // unused bits never store, so a careless write cannot leave ones there
                    wcr_ff[i*8 +: 8] <= wb_dat_i[i*8 +: 8] & WCR_WRITABLE_MASK[i*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wbDat_ff <= '0;
        end else if (wbReq && !wb_we_i) begin
            unique case (wb_adr_i)
                WCR_OFFSET:  wbDat_ff <= wcr_ff & WCR_WRITABLE_MASK;
                STAT_OFFSET: wbDat_ff <= {29'h0, state_ff, !csN_ff};
                default:     wbDat_ff <= '0;
            endcase
        end
    end

    // bus clock runs at half rate; accesses start only as it rises
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busClk_ff <= 1'b0;
        end else begin
            busClk_ff <= !busClk_ff;
        end
    end

    assign accept   = (state_ff == ST_IDLE) && accReq && !accDone_ff && !busClk_ff;
    assign waitHeld = !wcr_ff[IGN_BIT] && !extWaitN;
    assign waitCycles = curWrite_ff
        ? writeWaits(wcr_ff[WRWAIT_LSB +: 3], wcr_ff[RDWAIT_LSB +: 4])
        : readWaits(wcr_ff[RDWAIT_LSB +: 4]);
    // pins set on the accept edge must not show the previous access's direction or lanes
    assign pinWrite = accept ? accWrite : curWrite_ff;
    assign pinBe    = accept ? accByteEn : curBe_ff;
    assign pinBs    = accept ? byteSelMode : curBs_ff;

    always_comb begin
        nxt_state = state_ff;
        timerLoad = 1'b0;
        timerVal  = '0;
        unique case (state_ff)
            ST_IDLE: begin
                if (accept) begin
                    nxt_state = ST_SETUP;
                    timerLoad = 1'b1;
                    timerVal  = CNT_W'({wcr_ff[SETUP_LSB +: 2], 1'b0});
                end
            end
            ST_SETUP: begin
                if (expired) begin
                    nxt_state = ST_STROBE;
                    timerLoad = 1'b1;
                    timerVal  = oddHalves(waitCycles);
                end
            end
            ST_STROBE: begin
                // the wait input is checked at the end of the strobe, even with no waits
                if (expired && !waitHeld) begin
                    nxt_state = ST_HOLD;
                    timerLoad = 1'b1;
                    timerVal  = CNT_W'({wcr_ff[HW_LSB +: 2], 1'b0});
                end
            end
            ST_HOLD: begin
                if (expired) begin
                    nxt_state = ST_IDLE;
                end
            end
        endcase
    end

    asswc_timer u_timer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .load    (timerLoad),
        .loadVal (timerVal),
        .expired (expired)
    );

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            curWrite_ff <= 1'b0;
            curBe_ff    <= '0;
            curBs_ff    <= 1'b0;
            memAddr_ff  <= '0;
            memWdata_ff <= '0;
        end else if (accept) begin
            curWrite_ff <= accWrite;
            curBe_ff    <= accByteEn;
            curBs_ff    <= byteSelMode;
            memAddr_ff  <= accAddr;
            memWdata_ff <= accWdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            accDone_ff  <= 1'b0;
            accRdata_ff <= '0;
        end else begin
            accDone_ff <= (state_ff == ST_HOLD) && expired;
            if (state_ff == ST_STROBE && nxt_state == ST_HOLD && !curWrite_ff) begin
                accRdata_ff <= memRdata;
            end
        end
    end

    // pins are decoded from the next state so each one leaves a flip-flop
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            csN_ff   <= 1'b1;
            rdN_ff   <= 1'b1;
            beN_ff   <= 4'hf;
            rdWrN_ff <= 1'b1;
            oeN_ff   <= 1'b1;
        end else begin
            csN_ff   <= (nxt_state == ST_IDLE);
            rdN_ff   <= !(nxt_state == ST_STROBE && !pinWrite);
            oeN_ff   <= !(nxt_state != ST_IDLE && pinWrite);
            beN_ff   <= 4'hf;
            rdWrN_ff <= 1'b1;
            if (pinBs && wcr_ff[STYLE_BIT]) begin
                if (nxt_state != ST_IDLE) begin
                    beN_ff <= ~pinBe;
                end
                rdWrN_ff <= !(nxt_state == ST_STROBE && pinWrite);
            end else begin
                if (nxt_state == ST_STROBE && (pinWrite || pinBs)) begin
                    beN_ff <= ~pinBe;
                end
                rdWrN_ff <= !(nxt_state != ST_IDLE && pinWrite);
            end
        end
    end

    assign wb_dat_o        = wbDat_ff;
    assign wb_ack_o        = wbAck_ff;
    assign accDone         = accDone_ff;
    assign accRdata        = accRdata_ff;
    assign memBusClk       = busClk_ff;
    assign chipSelectN     = csN_ff;
    assign readStrobeN     = rdN_ff;
    assign byteLaneEnableN = beN_ff;
    assign rdWrN           = rdWrN_ff;
    assign memAddr         = memAddr_ff;
    assign memWdata        = memWdata_ff;
    assign memDataOeN      = oeN_ff;

    // helper: clocks spent in the current state
    always_ff @(posedge clk_sys) begin
        if (rst || state_ff != nxt_state) begin
            phaseCnt_ff <= '0;
        end else if (phaseCnt_ff != '1) begin
            phaseCnt_ff <= phaseCnt_ff + CNT_W'(1);
        end
    end

    sequence s_strobe_end;
        state_ff == ST_STROBE && expired;
    endsequence

    a_reserved_read_zero: assert property (@(posedge clk_sys) disable iff (rst)
        (wbReq && !wb_we_i && wb_adr_i == WCR_OFFSET) |=>
            (wb_ack_o && wb_dat_o[31:21] == '0 && !wb_dat_o[19] && wb_dat_o[15:13] == '0))
        else $error("reserved wait register bits read nonzero");

    a_plain_mode_status: assert property (@(posedge clk_sys) disable iff (rst)
        (!curBs_ff && !csN_ff && curWrite_ff && state_ff != ST_STROBE) |-> beN_ff == 4'hf)
        else $error("byte enables active outside the write strobe in plain mode");

    a_style0_strobe: assert property (@(posedge clk_sys) disable iff (rst)
        (curBs_ff && !wcr_ff[STYLE_BIT] && curWrite_ff && !csN_ff) |->
            (!rdWrN_ff && (beN_ff == 4'hf) == (state_ff != ST_STROBE)))
        else $error("style 0 strobe or status wrong");

    a_style1_status: assert property (@(posedge clk_sys) disable iff (rst)
        (curBs_ff && wcr_ff[STYLE_BIT] && !csN_ff) |->
            (beN_ff == ~curBe_ff && rdWrN_ff == !(state_ff == ST_STROBE && curWrite_ff)))
        else $error("style 1 status or strobe wrong");

    a_write_same_wait: assert property (@(posedge clk_sys) disable iff (rst)
        (s_strobe_end and (curWrite_ff && wcr_ff[WRWAIT_LSB +: 3] == 3'h0)) |->
            phaseCnt_ff >= oddHalves(readWaits(wcr_ff[RDWAIT_LSB +: 4])))
        else $error("write with code 000 shorter than the read wait");
    a_write_wait_len: assert property (@(posedge clk_sys) disable iff (rst)
        (s_strobe_end and (curWrite_ff && wcr_ff[IGN_BIT] && wcr_ff[WRWAIT_LSB +: 3] != 3'h0)) |->
            phaseCnt_ff == CNT_W'({wcr_ff[WRWAIT_LSB +: 3], 1'b0}) - CNT_W'(1))
        else $error("write strobe width not code minus one cycles");
    a_setup_delay: assert property (@(posedge clk_sys) disable iff (rst)
        (state_ff == ST_SETUP && nxt_state == ST_STROBE) |->
            (phaseCnt_ff == CNT_W'({wcr_ff[SETUP_LSB +: 2], 1'b0}) ##1 csN_ff == 1'b0))
        else $error("setup delay wrong");
    a_read_wait_len: assert property (@(posedge clk_sys) disable iff (rst)
        (s_strobe_end and (!curWrite_ff && wcr_ff[IGN_BIT])) |->
            phaseCnt_ff == oddHalves(readWaits(wcr_ff[RDWAIT_LSB +: 4])))
        else $error("read strobe width wrong");
    a_ext_wait_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (s_strobe_end and (!wcr_ff[IGN_BIT] && !extWaitN)) |=> state_ff == ST_STROBE)
        else $error("external wait not honoured");

    a_half_step_edge: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(csN_ff) |-> busClk_ff)
        else $error("chip select not aligned to the bus clock rising edge");
endmodule
`default_nettype wire

// >>> inc/asswc_pkg.sv
// constants, register layout and state codes for the area-4 sram strobe/wait controller
// assumes one 250 MHz clock; one clock period is one half of an external bus cycle
package asswc_pkg;

    // register offsets on the wishbone slave (byte addresses)
    localparam logic [7:0]  WCR_OFFSET        = 8'h00;
    localparam logic [7:0]  STAT_OFFSET       = 8'h04;

    // field positions of area4_wait_control
    localparam int          STYLE_BIT         = 20;
    localparam int          WRWAIT_LSB        = 16;
    localparam int          SETUP_LSB         = 11;
    localparam int          RDWAIT_LSB        = 7;
    localparam int          IGN_BIT           = 6;
    localparam int          HW_LSB            = 0;

    // bits that store a value; every other bit reads as zero
    localparam logic [31:0] WCR_WRITABLE_MASK = 32'h0017_1fc3;
    localparam logic [31:0] WCR_RESET         = 32'h0000_0500;

    // external bus timing
    localparam int          CLK_MHZ           = 250;
    localparam int          HALVES_PER_CYCLE  = 2;
    localparam int          CNT_W             = 6;

    // read wait codes at and above this value are prohibited
    localparam logic [3:0]  RDWAIT_BAD_CODE   = 4'hd;
    localparam logic [4:0]  RDWAIT_BAD_WAIT   = 5'h18;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SETUP  = 2'b01,
        ST_STROBE = 2'b10,
        ST_HOLD   = 2'b11
    } asswc_state_e;

endpackage

// >>> logic/asswc_timer.sv
// half-cycle down counter used to time setup, strobe width and hold phases
// assumes load is a one-cycle request; the count stops at zero
`timescale 1ns/1ps
`default_nettype none
module asswc_timer
    import asswc_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] loadVal,
    output logic                  expired
);
    logic [CNT_W-1:0] count_ff;

    // one decrement per clock: each clock is half a bus cycle, so phases land on either bus edge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_ff <= '0;
        end else if (load) begin
            count_ff <= loadVal;
        end else if (count_ff != '0) begin
            count_ff <= count_ff - CNT_W'(1);
        end
    end

    assign expired = (count_ff == '0);

    a_timer_stops: assert property (@(posedge clk_sys) disable iff (rst)
        (!load && count_ff == '0) |=> count_ff == '0)
        else $error("timer left zero without a load");
endmodule
`default_nettype wire

// >>> verification/asswc_sram_model.sv
// behavioural sram at the far side of the area-4 bus
// assumes registered active-low pins from the controller; extWaitN has a pull-up
`timescale 1ns/1ps
`default_nettype none
module asswc_sram_model (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [7:0]  stallClks,
    input  wire logic        chipSelectN,
    input  wire logic        readStrobeN,
    input  wire logic [3:0]  byteLaneEnableN,
    input  wire logic        rdWrN,
    input  wire logic [25:0] memAddr,
    input  wire logic [31:0] memWdata,
    input  wire logic        memDataOeN,
    output logic      [31:0] memRdata,
    output logic             extWaitN
);
    logic [31:0] mem [16];
    logic [31:0] lastRd_ff;
    logic [31:0] datPrev_ff;
    logic [7:0]  stall_ff;
    logic [3:0]  lanePrev_ff;
    logic [3:0]  adrPrev_ff;
    logic        wrActPrev_ff;
    logic        wrAct;
    logic        strobeOn;

    assign wrAct    = !memDataOeN && byteLaneEnableN != 4'hf && !rdWrN;
    assign strobeOn = !readStrobeN || byteLaneEnableN != 4'hf || !rdWrN;
    // a released bus toggles so a stale word can never pass as read data
    assign memRdata = (!chipSelectN && memDataOeN) ? mem[memAddr[3:0]] : ~lastRd_ff;
    assign extWaitN = chipSelectN || stall_ff == 8'h00;

    always_ff @(posedge clk_sys) begin
        lastRd_ff <= rst ? 32'h5a5a_5a5a : memRdata;
    end

    always_ff @(posedge clk_sys) begin
        if (chipSelectN) begin
            stall_ff <= stallClks;
        end else if (strobeOn && stall_ff != 8'h00) begin
            stall_ff <= stall_ff - 8'h01;
        end
    end

    // data lands when the earlier of lane strobe and direction strobe ends
    always_ff @(posedge clk_sys) begin
        wrActPrev_ff <= wrAct;
        lanePrev_ff  <= byteLaneEnableN;
        adrPrev_ff   <= memAddr[3:0];
        datPrev_ff   <= memWdata;
        if (wrActPrev_ff && !wrAct) begin
            for (int b = 0; b < 4; b++) begin
                if (!lanePrev_ff[b]) begin
                    mem[adrPrev_ff][8*b +: 8] <= datPrev_ff[8*b +: 8];
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> verification/area4_sram_strobe_wait_control_tb.sv
// self-checking bench for the area-4 strobe and wait controller
// assumes asswc_ctrl and the sram model; one 250 MHz clock, reset held 12 cycles
`timescale 1ns/1ps
`default_nettype none
module area4_sram_strobe_wait_control_tb;
    import asswc_pkg::*;
    logic        clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, memBusClk;
    logic        accReq, accWrite, accDone, byteSelMode, extWaitN;
    logic        chipSelectN, readStrobeN, rdWrN, memDataOeN;
    logic [3:0]  wb_sel_i, accByteEn, byteLaneEnableN;
    logic [7:0]  wb_adr_i, stallClks;
    logic [25:0] accAddr, memAddr;
    logic [31:0] wb_dat_i, wb_dat_o, accWdata, accRdata, memRdata, memWdata, q;
    int          error_cnt, compares, cyc, nCs, nLane, nRdwr, nPre;
    int          rw [14] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24, 24};

    asswc_ctrl asswc_ctrl_i (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .accReq(accReq),
        .accWrite(accWrite), .accAddr(accAddr), .accWdata(accWdata), .accByteEn(accByteEn),
        .accDone(accDone), .accRdata(accRdata), .byteSelMode(byteSelMode),
        .extWaitN(extWaitN), .memRdata(memRdata), .memBusClk(memBusClk),
        .chipSelectN(chipSelectN), .readStrobeN(readStrobeN),
        .byteLaneEnableN(byteLaneEnableN), .rdWrN(rdWrN), .memAddr(memAddr),
        .memWdata(memWdata), .memDataOeN(memDataOeN));

    asswc_sram_model asswc_sram_model_i (.clk_sys(clk_sys), .rst(rst), .stallClks(stallClks),
        .chipSelectN(chipSelectN), .readStrobeN(readStrobeN),
        .byteLaneEnableN(byteLaneEnableN), .rdWrN(rdWrN), .memAddr(memAddr),
        .memWdata(memWdata), .memDataOeN(memDataOeN), .memRdata(memRdata),
        .extWaitN(extWaitN));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("BAD %0t run timed out", $time);
            stop_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] wcr(int style, int wt, int su, int rd, int ign, int hw);
        return 32'(style) << STYLE_BIT | 32'(wt) << WRWAIT_LSB | 32'(su) << SETUP_LSB |
               32'(rd) << RDWAIT_LSB | 32'(ign) << IGN_BIT | 32'(hw) << HW_LSB;
    endfunction

    // clocks from the edge that drives accReq to the done pulse, when accept does not slip
    function automatic int nclk(int s, int w, int h);
        return 2 * s + 2 * w + 2 * h + 5;
    endfunction

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    // one access; accept may slip one clock to meet the bus clock phase
    task automatic acc(input logic w, input logic [25:0] a, input logic [31:0] d,
                       input int n0, input int slack);
        int   n;
        logic hit;
        n = 0;
        hit = 1'b0;
        nCs = 0;
        nLane = 0;
        nRdwr = 0;
        nPre = 0;
        @(posedge clk_sys);
        accReq   <= 1'b1;
        accWrite <= w;
        accAddr  <= a;
        accWdata <= d;
        do begin
            @(posedge clk_sys);
            n++;
            if (chipSelectN === 1'b0) begin
                nCs++;
                hit = hit || readStrobeN === 1'b0 || byteLaneEnableN !== 4'hf;
                if (!hit) nPre++;
                if (byteLaneEnableN !== 4'hf) nLane++;
                if (rdWrN === 1'b0) nRdwr++;
            end
        end while (accDone !== 1'b1);
        accReq <= 1'b0;
        q = accRdata;
        check(32'(n >= n0 + 1 && n <= n0 + 1 + slack), 32'h1);
    endtask

    initial begin
        rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, accReq, accWrite, byteSelMode} = '0;
        {wb_adr_i, wb_dat_i, wb_sel_i, accAddr, accWdata, stallClks} = '0;
        accByteEn = 4'hf;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        wb(1'b0, WCR_OFFSET, 32'h0);
        check(q, WCR_RESET);
        wb(1'b1, WCR_OFFSET, WCR_WRITABLE_MASK);
        wb(1'b0, WCR_OFFSET, 32'h0);
        check(q, WCR_WRITABLE_MASK);
        wb(1'b0, 8'h08, 32'h0);
        check(q, 32'h0);
        $display("test registers done");
        for (int c = 0; c < 14; c++) begin
            wb(1'b1, WCR_OFFSET, wcr(0, 0, 0, c, 1, 0));
            acc(1'b0, 26'(c), 32'h0, nclk(0, rw[c], 0), 1);
        end
        $display("test read waits done");
        for (int c = 0; c < 8; c++) begin
            wb(1'b1, WCR_OFFSET, wcr(0, c, 0, 3, 1, 0));
            acc(1'b1, 26'(c), 32'h0101_0101 * 32'(c), nclk(0, c == 0 ? 3 : c - 1, 0), 1);
        end
        acc(1'b0, 26'd5, 32'h0, nclk(0, 3, 0), 1);
        check(q, 32'h0505_0505);
        $display("test write waits done");
        for (int s = 0; s < 4; s++) begin
            wb(1'b1, WCR_OFFSET, wcr(0, 0, s, 0, 1, s));
            acc(1'b0, 26'd0, 32'h0, nclk(s, 0, s), 1);
            check(32'(nPre), 32'(2 * s + 1));
            check(32'(nCs), 32'(4 * s + 4));
        end
        $display("test setup delays done");
        for (int k = 0; k < 4; k++) begin
            byteSelMode <= (k != 3);
            wb(1'b1, WCR_OFFSET, wcr(k != 0, 0, 0, 1, 1, 0));
            acc(k != 2, 26'd9, 32'hc3a5_5a3c, nclk(0, 1, 0), 1);
            check(32'(nLane), (k == 1 || k == 2) ? 32'(nCs) : 32'h4);
            check(32'(nRdwr), k == 2 ? 32'h0 : k == 1 ? 32'h4 : 32'(nCs));
            check(32'(nCs), 32'h6);
            if (k == 2) check(q, 32'hc3a5_5a3c);
        end
        $display("test strobe styles done");
        byteSelMode <= 1'b0;
        stallClks <= 8'd6;
        for (int m = 0; m < 2; m++) begin
            wb(1'b1, WCR_OFFSET, wcr(0, 0, 0, 1, m, 0));
            acc(1'b0, 26'd9, 32'h0, nclk(0, 1, 0), m == 1 ? 1 : 7);
            check(32'(m == 1 ? nCs == 6 : nCs > 6), 32'h1);
        end
        $display("test external wait done");
        stop_test();
    end
endmodule
`default_nettype wire
